// [hdl/acs_defines.vh]
// What this block does
// (R01) track the selected channel during the first three serial clocks of a conversion
// (R02) hold and convert during the remaining thirteen serial clocks
// (R03) step the dac code by comparator result; final code is the result
// (R04) result is unsigned straight binary over 4096 steps
// (R05) powered while chip select low, powered down while high; code powers up at the 1st falling edge, down after the 16th
// (R06) continuous mode powers down from 16th falling edge to next 1st
// (R07) each conversion takes exactly 16 serial clocks
// (R08) conversions repeat back to back while chip select stays low
// (R09) host may raise chip select between conversions to save power
// (R10) falling edges 1-4 shift zeros, 5-16 shift result msb first
// (R11) first 8 rising edges carry control word; bits 5:3 pick next channel
// (R12) host gives each frame a multiple of sixteen rising edges
// (R13) data output high impedance and clock ignored while chip select high
// (R14) chip select rising mid-conversion abandons it and restarts fresh
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH
`define ACS_TRACK_CYCLES 5'd3
`define ACS_FRAME_CYCLES 5'd16
`define ACS_ZERO_EDGES 5'd4
`define ACS_CTRL_BITS 5'd8
`define ACS_CHAN_HI 5
`define ACS_CHAN_LO 3
`define ACS_RES_BITS 12
`define ACS_CHAN_RESET 3'h0
`define ACS_CODE_MID 12'h800
`endif

// [hdl/acs_buf2.v]
`timescale 1ns/1ps
`default_nettype none
// two-entry buffer for finished conversion words
module acs_buf2 (
  input wire core_clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [14:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output reg [14:0] out_data
);
  reg [14:0] slot1;
  reg [1:0] count;
  wire push;
  wire pop;
  assign in_ready = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count <= 2'd0;
      out_data <= 15'h0000;
      slot1 <= 15'h0000;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (count == 2'd0) out_data <= in_data;
          else slot1 <= in_data;
          count <= count + 2'd1;
        end
        2'b01: begin
          out_data <= slot1;
          count <= count - 2'd1;
        end
        2'b11: begin
          if (count == 2'd1) out_data <= in_data;
          else begin
            out_data <= slot1;
            slot1 <= in_data;
          end
        end
        default: begin
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [hdl/acs_sequencer.v]
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.vh"
module acs_sequencer (
  input wire core_clk,
  input wire rst,
  input wire cs_n_pin,
  input wire sclk_pin,
  input wire din_pin,
  output reg dout_o,
  output reg dout_oe,
  input wire comp_above,
  output reg [11:0] dac_code,
  output reg [2:0] channel_sel,
  output reg track_en,
  output reg powered,
  output wire result_valid,
  input wire result_ready,
  output wire [11:0] result_code,
  output wire [2:0] result_channel
);
  // ==========================================================
  // pin synchronisers
  reg [1:0] cs_sync;
  reg [1:0] sclk_sync;
  reg [1:0] din_sync;
  reg sclk_prev;
  reg cs_prev;
  wire cs_n;
  wire sclk;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_fall;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_sync <= 2'b11;
      sclk_sync <= 2'b00;
      din_sync <= 2'b00;
      sclk_prev <= 1'b0;
      cs_prev <= 1'b1;
    end else begin
      cs_sync <= {cs_sync[0], cs_n_pin};
      sclk_sync <= {sclk_sync[0], sclk_pin};
      din_sync <= {din_sync[0], din_pin};
      sclk_prev <= sclk_sync[1];
      cs_prev <= cs_sync[1];
    end
  end
  assign cs_n = cs_sync[1];
  assign sclk = sclk_sync[1];
  // clock is gated off while chip select is high
  assign sclk_rise = !cs_n && sclk && !sclk_prev; // R13
  // chip select falling with clock low counts as the first falling edge
  assign cs_fall = !cs_n && cs_prev;
  assign sclk_fall = !cs_n && ((!sclk && sclk_prev && !cs_fall) || (cs_fall && !sclk));

  // ==========================================================
  // conversion sequencing
  reg [4:0] fall_cnt;
  reg [4:0] rise_cnt;
  reg [7:0] ctrl_shift;
  reg [2:0] next_chan;
  reg [11:0] trial_bit;
  reg [11:0] shift_out;
  // finished word kept apart from the shifter so the last bit still goes out
  reg [14:0] done_word;
  reg in_conv;
  reg push_req;
  wire buf_ready;
  wire [11:0] next_dac;
  wire fall_track;
  assign next_dac = comp_above ? dac_code : (dac_code & ~trial_bit);
  assign fall_track = (fall_cnt < `ACS_TRACK_CYCLES);
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fall_cnt <= 5'd0;
      rise_cnt <= 5'd0;
      ctrl_shift <= 8'h00;
      next_chan <= `ACS_CHAN_RESET;
      channel_sel <= `ACS_CHAN_RESET;
      dac_code <= `ACS_CODE_MID;
      trial_bit <= `ACS_CODE_MID;
      shift_out <= 12'h000;
      done_word <= 15'h0000;
      track_en <= 1'b0;
      powered <= 1'b0;
      in_conv <= 1'b0;
      push_req <= 1'b0;
      dout_o <= 1'b0;
      dout_oe <= 1'b0;
    end else begin
      if (push_req && buf_ready) push_req <= 1'b0;
      if (cs_n) begin
        // abandon any conversion; next frame starts fresh
        fall_cnt <= 5'd0; // R14
        rise_cnt <= 5'd0; // R14
        in_conv <= 1'b0; // R14
        track_en <= 1'b0;
        powered <= 1'b0; // R05
        dout_oe <= 1'b0; // R13
        dout_o <= 1'b0;
      end else begin
        powered <= in_conv || sclk_fall || cs_fall; // R05 R06
        dout_oe <= 1'b1; // R13
        if (sclk_rise) begin
          rise_cnt <= (rise_cnt == `ACS_FRAME_CYCLES - 5'd1) ? 5'd0 : rise_cnt + 5'd1; // R07
          if (rise_cnt < `ACS_CTRL_BITS) ctrl_shift <= {ctrl_shift[6:0], din_sync[1]}; // R11
          if (rise_cnt == `ACS_CTRL_BITS - 5'd1) begin
            next_chan <= ctrl_shift[4:2]; // R11
          end
        end
        if (sclk_fall) begin
          if (fall_cnt == 5'd0) begin
            // 1st falling edge: start tracking the chosen input
            in_conv <= 1'b1; // R08
            track_en <= 1'b1; // R01
            channel_sel <= next_chan; // R01
            dac_code <= `ACS_CODE_MID;
            trial_bit <= `ACS_CODE_MID;
            shift_out <= done_word[11:0]; // R10
          end
          if (fall_cnt == `ACS_TRACK_CYCLES) track_en <= 1'b0; // R02
          if (!fall_track && trial_bit != 12'h000) begin
            // successive approximation: keep or drop trial bit, try next
            dac_code <= next_dac | (trial_bit >> 1); // R03
            trial_bit <= trial_bit >> 1; // R03
            if (trial_bit == 12'h001) begin
              done_word <= {channel_sel, next_dac}; // R04
              push_req <= 1'b1;
            end
          end
          // edges 1-4 drive zeros, 5-16 drive the previous result msb first
          if (fall_cnt < `ACS_ZERO_EDGES) dout_o <= 1'b0; // R10
          else if (fall_cnt != 5'd0) begin
            dout_o <= shift_out[`ACS_RES_BITS - 1]; // R10
            shift_out <= {shift_out[10:0], 1'b0}; // R10
          end
          if (fall_cnt == `ACS_FRAME_CYCLES - 5'd1) begin
            fall_cnt <= 5'd0; // R08
            in_conv <= 1'b0; // R06
          end else begin
            fall_cnt <= fall_cnt + 5'd1; // R07
          end
        end
      end
    end
  end

  // ==========================================================
  // finished words toward the user side
  acs_buf2 u_buf (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(push_req),
    .in_ready(buf_ready),
    .in_data(done_word),
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data({result_channel, result_code})
  );
endmodule
`default_nettype wire

// [dv/acs_props.sv]
`timescale 1ns/1ps
`default_nettype none
module acs_props (
  input wire core_clk, input wire rst, input wire cs_n_pin,
  input wire sclk_pin, input wire dout_o, input wire dout_oe,
  input wire track_en, input wire powered, input wire result_valid,
  input wire result_ready, input wire [11:0] result_code
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ====
  // falling clock edges seen since chip select fell, modulo sixteen
  reg s_d;
  reg [3:0] nfall;
  always @(posedge core_clk) begin
    s_d <= sclk_pin;
    nfall <= cs_n_pin ? 4'h0 : nfall + {3'h0, s_d & ~sclk_pin};
  end
  sequence cs_idle; cs_n_pin [*4]; endsequence
  sequence cs_busy; !cs_n_pin [*5]; endsequence
  a_oe_off_idle: assert property (cs_idle |-> !dout_oe)
    else $error("output driven while idle");
  a_oe_on_busy: assert property (cs_busy |-> dout_oe)
    else $error("output not driven in frame");
  a_pwr_off_idle: assert property (cs_idle |-> !powered)
    else $error("powered while idle");
  a_trk_off_idle: assert property (cs_idle |-> !track_en)
    else $error("tracking while idle");
  a_track_start: assert property ($rose(track_en) |-> nfall == 4'h1)
    else $error("tracking began off first edge");
  a_track_three: assert property ($fell(track_en) && !cs_n_pin |-> nfall == 4'h4)
    else $error("tracking not three clocks");
  a_zero_lead: assert property ($rose(track_en) |-> ##2 (!dout_o) [*8])
    else $error("leading bit not zero");
  a_head_hold: assert property (result_valid && !result_ready |=>
    result_valid && $stable(result_code)) else $error("stalled word lost");
endmodule
bind acs_sequencer acs_props acs_props_i (.core_clk, .rst, .cs_n_pin, .sclk_pin, .dout_o,
  .dout_oe, .track_en, .powered, .result_valid, .result_ready, .result_code);
`default_nettype wire

// [dv/acs_host.sv]
`timescale 1ns/1ps
`default_nettype none
// ====
// host master: chip select, serial clock, control bits msb first
module acs_host (
  input wire logic core_clk,
  input wire logic dout,
  output logic cs_n,
  output logic sclk,
  output logic din
);
  initial {cs_n, sclk, din} = 3'b110;
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic conv(input logic [7:0] ctl, input int nedge, output logic [15:0] rx);
    rx = 16'h0;
    for (int i = 0; i < nedge; i++) begin
      sclk = 1'b0;
      din = (i < 8) ? ctl[7 - i] : 1'($urandom);
      tick(4);
      sclk = 1'b1;
      tick(3);
      rx = {rx[14:0], dout};
      tick(1);
    end
  endtask
  task automatic select(input logic v);
    cs_n = v;
    tick(4);
  endtask
endmodule
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0, rst = 1'b1, result_ready = 1'b0, stall = 1'b0;
  logic [11:0] vin = 12'h0, prev = 12'h0;
  logic [2:0] ch = 3'h0;
  logic [7:0] ctl;
  logic [15:0] rx;
  logic [14:0] q[$];
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  wire cs_n, sclk, din, dout_o, dout_oe, track_en, powered, result_valid;
  wire [11:0] dac_code, result_code;
  wire [2:0] channel_sel, result_channel;
  wire dout = dout_oe ? dout_o : 1'bz;
  always #5 core_clk = ~core_clk;
  acs_host acs_host_i (.core_clk, .dout, .cs_n, .sclk, .din);
  acs_sequencer acs_sequencer_i (.core_clk, .rst, .cs_n_pin(cs_n), .sclk_pin(sclk),
    .din_pin(din), .dout_o, .dout_oe, .comp_above(vin >= dac_code), .dac_code,
    .channel_sel, .track_en, .powered, .result_valid, .result_ready, .result_code,
    .result_channel);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one conversion; short ones are abandoned and keep the channel
  task automatic one(input logic [11:0] level, input int nedge);
    vin = level;
    ctl = 8'($urandom);
    if (nedge < 16) ctl[5:3] = ch;
    if (nedge == 16) q.push_back({ch, level});
    acs_host_i.conv(ctl, nedge, rx);
    if (nedge == 16) check(rx, {4'h0, prev});
    if (nedge == 16) prev = level;
    ch = ctl[5:3];
  endtask
  always @(posedge core_clk) result_ready <= #1 !stall && 1'($urandom);
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      tally_and_finish;
    end else if (result_valid === 1'b1 && result_ready)
      check({1'b0, result_channel, result_code}, {1'b0, q.pop_front()});
  end
  initial begin
    void'($urandom(64));
    repeat (12) @(posedge core_clk);
    #1 rst = 1'b0;
    acs_host_i.tick(4);
    for (int f = 0; f < 8; f++) begin
      acs_host_i.select(1'b0);
      repeat (1 + $urandom % 3)
        one(f == 0 ? 12'hfff : f == 1 ? 12'h000 : 12'($urandom), 16);
      acs_host_i.select(1'b1);
    end
    $display("random frames done");
    stall = 1'b1;
    acs_host_i.select(1'b0);
    one(12'h5a5, 16);
    one(12'h001, 16);
    acs_host_i.select(1'b1);
    check({15'h0, result_valid}, 16'h1);
    stall = 1'b0;
    acs_host_i.tick(30);
    check({15'h0, result_valid}, 16'h0);
    $display("stalled buffer done");
    acs_host_i.select(1'b0);
    one(12'h3c3, 10);
    acs_host_i.select(1'b1);
    acs_host_i.select(1'b0);
    one(12'h777, 16);
    acs_host_i.select(1'b1);
    acs_host_i.tick(30);
    $display("abort done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
